// File: hw/cris_pkg.sv
// constants, register map and types for the reset and interrupt sequencer
// ============================================================
package cris_pkg;

    // ============================================================
    // sizes
    localparam int unsigned PC_W = 17;
    localparam int unsigned SP_W = 16;
    localparam int unsigned DW = 8;
    localparam int unsigned AW = 8;
    localparam int unsigned N_FLAG = 4;
    localparam int unsigned N_LVL = 4;
    localparam int unsigned N_SRC = N_FLAG + N_LVL;
    localparam int unsigned SRC_W = 3;

    // ============================================================
    // program and stack memory layout
    localparam logic [PC_W-1:0] APP_BASE = 17'h00000;
    localparam logic [PC_W-1:0] BOOT_BASE = 17'h0f000;
    localparam logic [PC_W-1:0] VEC_STEP = 17'h00002;
    localparam logic [SP_W-1:0] SP_INIT = 16'h10ff;

    // ============================================================
    // timing in cpu clock cycles
    localparam logic [3:0] ENTRY_CYC = 4'h5;
    localparam logic [3:0] WAKE_CYC = 4'h5;
    localparam logic [3:0] RET_CYC = 4'h5;
    localparam logic [3:0] PIN_SYNC_CYC = 4'h2;

    // ============================================================
    // register offsets
    localparam logic [AW-1:0] REG_FLAG = 8'h00;
    localparam logic [AW-1:0] REG_ENABLE = 8'h01;
    localparam logic [AW-1:0] REG_CORE_CTRL = 8'h02;
    localparam logic [AW-1:0] REG_STATUS = 8'h03;
    localparam logic [AW-1:0] REG_SP_LO = 8'h04;
    localparam logic [AW-1:0] REG_SP_HI = 8'h05;
    localparam logic [AW-1:0] REG_INFO = 8'h06;

    // field positions
    localparam int unsigned CTRL_VECTOR_TABLE_SELECT_BIT = 0;
    localparam int unsigned STATUS_GIE_BIT = 7;
    localparam int unsigned INFO_BUSY_BIT = 7;

    // ============================================================
    // sequencer states
    typedef enum logic [1:0] {
        ST_RST_VEC = 2'b00,
        ST_IDLE = 2'b01,
        ST_ENTRY = 2'b10,
        ST_RET = 2'b11
    } cris_state_e;

endpackage

// File: hw/cris_sequencer.sv
// reset and interrupt sequencer for the cpu core
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ps
module cris_sequencer
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // register port
    input wire logic [cris_pkg::AW-1:0] i_addr,
    input wire logic [cris_pkg::DW-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [cris_pkg::DW-1:0] o_rdata,
    // interrupt sources
    input wire logic [cris_pkg::N_FLAG-1:0] i_evt,
    input wire logic [cris_pkg::N_LVL-1:0] i_lvl_req,
    // fuse and lock pins
    input wire logic i_boot_reset_fuse,
    input wire logic i_app_lock_bit_b,
    input wire logic i_boot_lock_bit_b,
    // instruction sequencer
    input wire logic i_instr_done,
    input wire logic i_sei,
    input wire logic i_clear_global_enable_instr,
    input wire logic i_return_from_handler,
    input wire logic i_sleeping,
    input wire logic [cris_pkg::PC_W-1:0] i_pc,
    output logic o_busy,
    output logic o_vec_valid,
    output logic [cris_pkg::PC_W-1:0] o_vec_addr,
    output logic o_ret_valid,
    output logic [cris_pkg::PC_W-1:0] o_ret_pc,
    output logic o_gie,
    output logic [cris_pkg::SP_W-1:0] o_sp,
    // stack memory
    output logic o_stk_we,
    output logic o_stk_re,
    output logic [cris_pkg::SP_W-1:0] o_stk_addr,
    output logic [cris_pkg::DW-1:0] o_stk_wdata,
    input wire logic [cris_pkg::DW-1:0] i_stk_rdata
);
    import cris_pkg::*;

    // ============================================================
    // state record
    typedef struct packed {
        cris_state_e state;
        logic [3:0] cnt;
        logic [3:0] last;
        logic [SRC_W-1:0] src;
        logic [PC_W-1:0] ret_pc;
        logic [N_FLAG-1:0] flags;
        logic [N_SRC-1:0] enable;
        logic vector_table_select;
        logic gie;
        logic [SP_W-1:0] sp;
        logic [2:0] pin_s1;
        logic [2:0] pin_s2;
        logic [DW-1:0] rdata;
        logic busy;
        logic vec_valid;
        logic [PC_W-1:0] vec_addr;
        logic ret_valid;
        logic stk_we;
        logic stk_re;
        logic [SP_W-1:0] stk_addr;
        logic [DW-1:0] stk_wdata;
    } cris_state_s;

    cris_state_s st_reg;
    cris_state_s st_next;

    // ============================================================
    // functions
    // lowest index wins, the lowest vector address
    function automatic logic [SRC_W-1:0] first_set(input logic [N_SRC-1:0] v);
        logic [SRC_W-1:0] r;
        r = '0;
        for (int i = N_SRC - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                r = SRC_W'(i);
            end
        end
        return r;
    endfunction

    // vector slot zero belongs to reset, sources follow
    function automatic logic [PC_W-1:0] vec_of(input logic [SRC_W-1:0] s,
                                             input logic sel);
        logic [PC_W-1:0] base;
        base = sel ? BOOT_BASE : APP_BASE;
        return base + (PC_W'(s) + PC_W'(1)) * VEC_STEP;
    endfunction

    // ============================================================
    // reset release; kept outside the record so it can reset it
    logic rst_s1_reg;
    logic rst_n_reg;

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rst_s1_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end
        else
        begin
            rst_s1_reg <= 1'b1;
            rst_n_reg <= rst_s1_reg;
        end
    end

    // ============================================================
    // request view
    logic lk_app;
    logic lk_boot;
    logic fuse;
    logic pc_boot;
    logic suppress;
    logic [N_SRC-1:0] req;
    logic gie_eff;
    logic take;
    logic [SRC_W-1:0] win;

    // synced pins only; the first stage is never looked at
    assign fuse = st_reg.pin_s2[0];
    assign lk_app = st_reg.pin_s2[1];
    assign lk_boot = st_reg.pin_s2[2];
    assign pc_boot = (i_pc >= BOOT_BASE);

    // locked code may not leave for vectors in the other section
    assign suppress = (lk_app & ~pc_boot & st_reg.vector_table_select)
                    | (lk_boot & pc_boot & ~st_reg.vector_table_select);

    // flags hold on their own, levels count only while present
    assign req = {i_lvl_req, st_reg.flags} & st_reg.enable;

    // registered enable: the instruction that sets it runs first
    assign gie_eff = st_reg.gie & ~i_clear_global_enable_instr;

    // accept only on an instruction boundary or out of sleep
    assign take = (st_reg.state == ST_IDLE) & gie_eff & (|req) & ~suppress
                & ((i_instr_done & ~i_sei & ~i_return_from_handler)
                   | i_sleeping);
    assign win = first_set(req);

    // ============================================================
    // next-state logic
    always_comb
    begin
        logic [N_FLAG-1:0] clr;
        logic [SP_W-1:0] sp_w;
        clr = '0;
        sp_w = st_reg.sp;
        st_next = st_reg;
        st_next.pin_s1 = {i_boot_lock_bit_b, i_app_lock_bit_b,
                          i_boot_reset_fuse};
        st_next.pin_s2 = st_reg.pin_s1;
        st_next.vec_valid = 1'b0;
        st_next.ret_valid = 1'b0;
        st_next.stk_we = 1'b0;
        st_next.stk_re = 1'b0;
        st_next.rdata = '0;

        // register writes
        if (i_wr)
        begin
            unique case (i_addr)
                REG_FLAG:
                begin
                    clr = i_wdata[N_FLAG-1:0];
                end
                REG_ENABLE:
                begin
                    st_next.enable = i_wdata[N_SRC-1:0];
                end
                REG_CORE_CTRL:
                begin
                    st_next.vector_table_select = i_wdata[CTRL_VECTOR_TABLE_SELECT_BIT];
                end
                REG_STATUS:
                begin
                    // software may reopen nesting inside a handler
                    st_next.gie = i_wdata[STATUS_GIE_BIT];
                end
                REG_SP_LO:
                begin
                    sp_w[DW-1:0] = i_wdata;
                end
                REG_SP_HI:
                begin
                    sp_w[SP_W-1:DW] = i_wdata;
                end
                default:
                begin
                end
            endcase
        end
        st_next.sp = sp_w;

        // global enable instructions
        if (i_sei & i_instr_done)
        begin
            st_next.gie = 1'b1;
        end
        if (i_clear_global_enable_instr)
        begin
            st_next.gie = 1'b0;
        end

        // register reads, data in the following cycle
        if (i_rd)
        begin
            unique case (i_addr)
                REG_FLAG:
                begin
                    st_next.rdata = DW'(st_reg.flags);
                end
                REG_ENABLE:
                begin
                    st_next.rdata = DW'(st_reg.enable);
                end
                REG_CORE_CTRL:
                begin
                    st_next.rdata = DW'(st_reg.vector_table_select);
                end
                REG_STATUS:
                begin
                    st_next.rdata = {st_reg.gie, 7'h00};
                end
                REG_SP_LO:
                begin
                    st_next.rdata = st_reg.sp[DW-1:0];
                end
                REG_SP_HI:
                begin
                    st_next.rdata = st_reg.sp[SP_W-1:DW];
                end
                REG_INFO:
                begin
                    st_next.rdata = DW'(st_reg.src);
                    st_next.rdata[INFO_BUSY_BIT] = st_reg.busy;
                end
                default:
                begin
                    st_next.rdata = '0;
                end
            endcase
        end

        // sequencer
        unique case (st_reg.state)
            ST_RST_VEC:
            begin
                // wait for the fuse to pass its synchroniser
                st_next.cnt = st_reg.cnt + 4'h1;
                if (st_reg.cnt == PIN_SYNC_CYC)
                begin
                    st_next.vec_valid = 1'b1;
                    st_next.vec_addr = fuse ? BOOT_BASE : APP_BASE;
                    st_next.busy = 1'b0;
                    st_next.cnt = '0;
                    st_next.state = ST_IDLE;
                end
            end
            ST_IDLE:
            begin
                if (take)
                begin
                    st_next.state = ST_ENTRY;
                    st_next.busy = 1'b1;
                    st_next.cnt = '0;
                    // a wake from sleep stretches the entry
                    st_next.last = i_sleeping
                                 ? ENTRY_CYC + WAKE_CYC - 4'h1
                                 : ENTRY_CYC - 4'h1;
                    st_next.src = win;
                    st_next.ret_pc = i_pc;
                    st_next.gie = 1'b0;
                    if (win < SRC_W'(N_FLAG))
                    begin
                        clr[win[1:0]] = 1'b1;
                    end
                    // low byte goes first so it ends deepest
                    st_next.stk_we = 1'b1;
                    st_next.stk_addr = st_reg.sp;
                    st_next.stk_wdata = i_pc[DW-1:0];
                end
                else if (i_return_from_handler)
                begin
                    st_next.state = ST_RET;
                    st_next.busy = 1'b1;
                    st_next.cnt = '0;
                    st_next.stk_re = 1'b1;
                    st_next.stk_addr = st_reg.sp + 16'h0001;
                end
            end
            ST_ENTRY:
            begin
                st_next.cnt = st_reg.cnt + 4'h1;
                if (st_reg.cnt == 4'h0)
                begin
                    st_next.stk_we = 1'b1;
                    st_next.stk_addr = st_reg.sp - 16'h0001;
                    st_next.stk_wdata = st_reg.ret_pc[2*DW-1:DW];
                end
                if (st_reg.cnt == 4'h1)
                begin
                    st_next.stk_we = 1'b1;
                    st_next.stk_addr = st_reg.sp - 16'h0002;
                    st_next.stk_wdata = DW'(st_reg.ret_pc[PC_W-1:2*DW]);
                end
                if (st_reg.cnt == st_reg.last)
                begin
                    st_next.sp = st_reg.sp - 16'h0003;
                    st_next.vec_valid = 1'b1;
                    st_next.vec_addr = vec_of(st_reg.src, st_reg.vector_table_select);
                    st_next.busy = 1'b0;
                    st_next.state = ST_IDLE;
                end
            end
            ST_RET:
            begin
                st_next.cnt = st_reg.cnt + 4'h1;
                // top byte comes back first, reverse of the push
                if (st_reg.cnt == 4'h0)
                begin
                    st_next.stk_re = 1'b1;
                    st_next.stk_addr = st_reg.sp + 16'h0002;
                end
                if (st_reg.cnt == 4'h1)
                begin
                    st_next.stk_re = 1'b1;
                    st_next.stk_addr = st_reg.sp + 16'h0003;
                    st_next.ret_pc[PC_W-1:2*DW] = i_stk_rdata[0];
                end
                if (st_reg.cnt == 4'h2)
                begin
                    st_next.ret_pc[2*DW-1:DW] = i_stk_rdata;
                end
                if (st_reg.cnt == 4'h3)
                begin
                    st_next.ret_pc[DW-1:0] = i_stk_rdata;
                end
                if (st_reg.cnt == RET_CYC - 4'h1)
                begin
                    st_next.sp = st_reg.sp + 16'h0003;
                    st_next.gie = 1'b1;
                    st_next.ret_valid = 1'b1;
                    st_next.busy = 1'b0;
                    st_next.state = ST_IDLE;
                end
            end
        endcase

        // a new event beats a clear in the same cycle
        st_next.flags = (st_reg.flags & ~clr) | i_evt;
    end

    // ============================================================
    // record register
    always_ff @(posedge i_clk or negedge rst_n_reg)
    begin
        if (!rst_n_reg)
        begin
            st_reg <= '0;
            st_reg.state <= ST_RST_VEC;
            st_reg.busy <= 1'b1;
            st_reg.sp <= SP_INIT;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ============================================================
    // outputs straight from the record
    assign o_rdata = st_reg.rdata;
    assign o_busy = st_reg.busy;
    assign o_vec_valid = st_reg.vec_valid;
    assign o_vec_addr = st_reg.vec_addr;
    assign o_ret_valid = st_reg.ret_valid;
    assign o_ret_pc = st_reg.ret_pc;
    assign o_gie = st_reg.gie;
    assign o_sp = st_reg.sp;
    assign o_stk_we = st_reg.stk_we;
    assign o_stk_re = st_reg.stk_re;
    assign o_stk_addr = st_reg.stk_addr;
    assign o_stk_wdata = st_reg.stk_wdata;

endmodule // cris_sequencer

// File: sim/cris_chk.sv
// assertion checker for the reset and interrupt sequencer ports
`timescale 1ns/1ps
module cris_chk
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // instruction sequencer side
    input wire logic i_instr_done,
    input wire logic i_sei,
    input wire logic i_clear_global_enable_instr,
    input wire logic o_busy,
    input wire logic o_vec_valid,
    input wire logic [cris_pkg::PC_W-1:0] o_vec_addr,
    input wire logic o_ret_valid,
    input wire logic o_gie,
    input wire logic [cris_pkg::SP_W-1:0] o_sp,
    // stack side
    input wire logic o_stk_we,
    input wire logic o_stk_re,
    input wire logic [cris_pkg::SP_W-1:0] o_stk_addr
);
    import cris_pkg::*;
    // ============================================================
    // one clock domain, so clocking and disable are shared
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    // entry may only start with global enable, and clears it
    property p_take_gie;
        $rose(o_stk_we) |-> $past(o_gie) && !o_gie;
    endproperty
    a_take_gie: assert property (p_take_gie) else $error("entry gie bad");
    // three pushes going down from the pointer, then a quiet cycle
    property p_push_addr;
        $rose(o_stk_we) |-> o_stk_addr == o_sp ##1
            o_stk_we && o_stk_addr == o_sp - 16'h1 ##1
            o_stk_we && o_stk_addr == o_sp - 16'h2 ##1 !o_stk_we;
    endproperty
    a_push_addr: assert property (p_push_addr) else $error("push order bad");
    // five busy cycles before the vector, wake adds at most five more
    property p_entry_len;
        $rose(o_stk_we) |-> (o_busy && !o_vec_valid) [*5] ##[1:6] o_vec_valid;
    endproperty
    a_entry_len: assert property (p_entry_len) else $error("entry length bad");
    // return pops for three cycles, ends after five busy cycles with gie set
    property p_ret_len;
        $rose(o_stk_re) |-> o_stk_re [*3] ##1 !o_stk_re ##2 o_ret_valid && o_gie;
    endproperty
    a_ret_len: assert property (p_ret_len) else $error("return length bad");
    property p_pop_addr;
        $rose(o_stk_re) |-> o_stk_addr == o_sp + 16'h1;
    endproperty
    a_pop_addr: assert property (p_pop_addr) else $error("pop address bad");
    property p_ret_sp;
        o_ret_valid |-> o_sp == $past(o_sp) + 16'h3;
    endproperty
    a_ret_sp: assert property (p_ret_sp) else $error("return sp bad");
    // a same-cycle request must lose against the clear instruction
    property p_clear;
        i_clear_global_enable_instr && !o_busy |=> !o_gie && !o_stk_we;
    endproperty
    a_clear: assert property (p_clear) else $error("clear not at once");
    property p_sei_wait;
        i_sei && i_instr_done && !o_busy |=> !o_stk_we;
    endproperty
    a_sei_wait: assert property (p_sei_wait) else $error("take after sei");
    // vectors are even and sit in the low slots of either section
    property p_vec_base;
        o_vec_valid |-> !o_vec_addr[0] && (o_vec_addr < 17'h00012 ||
            (o_vec_addr >= BOOT_BASE && o_vec_addr < BOOT_BASE + 17'h00012));
    endproperty
    a_vec_base: assert property (p_vec_base) else $error("vector bad");
    c_entry: cover property ($rose(o_stk_we));
    c_return: cover property (o_ret_valid);
    c_boot_vec: cover property (o_vec_valid && o_vec_addr >= BOOT_BASE);
endmodule // cris_chk

bind cris_sequencer cris_chk cris_chk_inst (.*);

// File: sim/cris_stack_model.sv
// stack memory model facing the sequencer stack port
`timescale 1ns/1ps
module cris_stack_model
(
    // clock
    input wire logic i_clk,
    // stack port
    input wire logic i_we,
    input wire logic i_re,
    input wire logic [cris_pkg::SP_W-1:0] i_addr,
    input wire logic [cris_pkg::DW-1:0] i_wdata,
    output logic [cris_pkg::DW-1:0] o_rdata
);
    import cris_pkg::*;
    logic [DW-1:0] mem_reg [256];
    logic [DW-1:0] rdata_reg = 8'h5a;
    // only pc bytes land here; the status byte is the handler's job
    // data toggles outside reads so a stale byte never passes as valid
    always @(posedge i_clk)
    begin
        if (i_we)
            mem_reg[i_addr[7:0]] <= i_wdata;
        if (i_re)
            rdata_reg <= mem_reg[i_addr[7:0]];
        else
            rdata_reg <= ~rdata_reg;
    end
    assign o_rdata = rdata_reg;
endmodule // cris_stack_model

// File: sim/tb.sv
// self-checking testbench for the reset and interrupt sequencer
`timescale 1ns/1ps
module tb;
    import cris_pkg::*;
    logic i_clk = 1'b0, i_arst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
    logic [AW-1:0] i_addr = '0;
    logic [DW-1:0] i_wdata = '0, o_rdata, o_stk_wdata, i_stk_rdata;
    logic [N_FLAG-1:0] i_evt = '0;
    logic [N_LVL-1:0] i_lvl_req = '0;
    logic i_boot_reset_fuse = 1'b0, i_app_lock_bit_b = 1'b0;
    logic i_boot_lock_bit_b = 1'b0, i_instr_done = 1'b0, i_sei = 1'b0;
    logic i_clear_global_enable_instr = 1'b0, i_return_from_handler = 1'b0;
    logic i_sleeping = 1'b0, o_busy, o_vec_valid, o_ret_valid, o_gie;
    logic o_stk_we, o_stk_re;
    logic [PC_W-1:0] i_pc = '0, o_vec_addr, o_ret_pc, pc = 17'h00abc, pc1;
    logic [SP_W-1:0] o_sp, o_stk_addr;
    logic [31:0] rng = 32'hc88b;
    logic [3:0] m;
    logic vector_table_select = 1'b0;
    int num_errors = 0, samples_checked = 0, s;

    always #5 i_clk = ~i_clk;
    cris_sequencer cris_sequencer_inst (.*);
    cris_stack_model cris_stack_model_inst (.i_clk(i_clk), .i_we(o_stk_we),
        .i_re(o_stk_re), .i_addr(o_stk_addr), .i_wdata(o_stk_wdata),
        .o_rdata(i_stk_rdata));

    // ============================================================
    // expectations and reporting
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    function automatic logic [PC_W-1:0] vec_exp(input int src);
        return (vector_table_select ? BOOT_BASE : APP_BASE) + PC_W'((src + 1) * 2);
    endfunction
    function automatic int low_bit(input logic [3:0] v);
        for (int i = 0; i < 4; i++)
            if (v[i])
                return i;
        return -1;
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("checked=%0d errors=%0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ============================================================
    // drivers: change after a rising edge, release a cycle later
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] exp);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        check(o_rdata, exp);
        @(posedge i_clk);
    endtask
    task automatic evt(input logic [3:0] e);
        i_evt <= e;
        @(posedge i_clk);
        i_evt <= '0;
        @(posedge i_clk);
    endtask
    task automatic sei();
        i_instr_done <= 1'b1;
        i_sei <= 1'b1;
        @(posedge i_clk);
        i_instr_done <= 1'b0;
        i_sei <= 1'b0;
        @(posedge i_clk);
    endtask
    // one boundary; src below zero means no entry may follow
    task automatic enter(input logic slp, input logic clr, input int src);
        int n;
        logic [PC_W-1:0] va;
        n = 0;
        va = '0;
        i_instr_done <= 1'b1;
        i_sleeping <= slp;
        i_clear_global_enable_instr <= clr;
        i_pc <= pc;
        @(posedge i_clk);
        i_instr_done <= 1'b0;
        i_clear_global_enable_instr <= 1'b0;
        for (int k = 1; k <= 12; k++)
        begin
            @(posedge i_clk);
            #1;
            if (o_vec_valid === 1'b1 && n == 0)
            begin
                n = k;
                va = o_vec_addr;
            end
        end
        i_sleeping <= 1'b0;
        @(posedge i_clk);
        check(n, src < 0 ? 0 : (slp ? 10 : 5));
        if (src >= 0)
            check(va, vec_exp(src));
    endtask
    task automatic ret(input logic [PC_W-1:0] exp_pc);
        int n;
        logic [PC_W-1:0] rp;
        n = 0;
        rp = '0;
        i_return_from_handler <= 1'b1;
        @(posedge i_clk);
        i_return_from_handler <= 1'b0;
        for (int k = 1; k <= 8; k++)
        begin
            @(posedge i_clk);
            #1;
            if (o_ret_valid === 1'b1 && n == 0)
            begin
                n = k;
                rp = o_ret_pc;
            end
        end
        @(posedge i_clk);
        check(n, 5);
        check(rp, exp_pc);
        check(o_gie, 1'b1);
    endtask
    task automatic rst(input logic fuse);
        logic [PC_W-1:0] va;
        va = 17'h1ffff;
        i_boot_reset_fuse <= fuse;
        i_arst_n <= 1'b0;
        repeat (8) @(posedge i_clk);
        i_arst_n <= 1'b1;
        for (int k = 1; k <= 12; k++)
        begin
            @(posedge i_clk);
            #1;
            if (o_vec_valid === 1'b1)
                va = o_vec_addr;
        end
        @(posedge i_clk);
        check(va, fuse ? BOOT_BASE : APP_BASE);
        check(o_busy, 1'b0);
        vector_table_select = 1'b0;
    endtask

    // ============================================================
    // main sequence
    initial
    begin
        rst(1'b0);
        rd(REG_ENABLE, 8'h00);
        rd(REG_SP_LO, 8'hff);
        rd(REG_SP_HI, 8'h10);
        rd(8'h07, 8'h00);
        // flag latches while disabled, write one clears, zero keeps
        evt(4'h4);
        rd(REG_FLAG, 8'h04);
        wr(REG_FLAG, 8'h00);
        rd(REG_FLAG, 8'h04);
        wr(REG_FLAG, 8'h04);
        rd(REG_FLAG, 8'h00);
        // pending flags wait for gie, then go by priority
        wr(REG_ENABLE, 8'hff);
        evt(4'ha);
        sei();
        enter(1'b0, 1'b0, 1);
        rd(REG_FLAG, 8'h08);
        rd(REG_INFO, 8'h01);
        rd(REG_STATUS, 8'h00);
        ret(pc);
        enter(1'b0, 1'b0, 3);
        ret(pc);
        // disabled source and clear instruction both block entry
        wr(REG_ENABLE, 8'h00);
        evt(4'h1);
        enter(1'b0, 1'b0, -1);
        wr(REG_ENABLE, 8'hff);
        enter(1'b0, 1'b1, -1);
        // wake from sleep, then nest a level source
        wr(REG_STATUS, 8'h80);
        pc1 = pc;
        enter(1'b1, 1'b0, 0);
        wr(REG_STATUS, 8'h80);
        i_lvl_req <= 4'h1;
        @(posedge i_clk);
        pc = 17'h01234;
        enter(1'b0, 1'b0, 4);
        i_lvl_req <= 4'h0;
        ret(pc);
        ret(pc1);
        // a level that vanishes before enable gives nothing
        enter(1'b0, 1'b1, -1);
        i_lvl_req <= 4'h2;
        repeat (2) @(posedge i_clk);
        i_lvl_req <= 4'h0;
        sei();
        enter(1'b0, 1'b0, -1);
        // relocated vectors and the lock bits
        vector_table_select = 1'b1;
        wr(REG_CORE_CTRL, 8'h01);
        evt(4'h4);
        enter(1'b0, 1'b0, 2);
        ret(pc);
        i_app_lock_bit_b <= 1'b1;
        pc = 17'h00100;
        evt(4'h4);
        enter(1'b0, 1'b0, -1);
        pc = 17'h0f100;
        enter(1'b0, 1'b0, 2);
        ret(pc);
        i_app_lock_bit_b <= 1'b0;
        i_boot_lock_bit_b <= 1'b1;
        vector_table_select = 1'b0;
        wr(REG_CORE_CTRL, 8'h00);
        evt(4'h4);
        enter(1'b0, 1'b0, -1);
        i_boot_lock_bit_b <= 1'b0;
        repeat (3) @(posedge i_clk);
        enter(1'b0, 1'b0, 2);
        ret(pc);
        // random masks served lowest source first, random return pcs
        repeat (6)
        begin
            rng = xs(rng);
            m = (rng[3:0] == 4'h0) ? 4'h8 : rng[3:0];
            evt(m);
            while (m != 4'h0)
            begin
                s = low_bit(m);
                rng = xs(rng);
                pc = rng[PC_W-1:0];
                enter(1'b0, 1'b0, s);
                ret(pc);
                m[s] = 1'b0;
            end
        end
        rst(1'b1);
        conclude();
    end

    // watchdog far beyond the fewer than a thousand cycles the tests need
    initial
    begin
        #500000;
        num_errors++;
        conclude();
    end
endmodule // tb
